// File: design/fmsp_serial_port.sv
// Four-mode serial port: registers, shift-register mode, UART framing
// What this block does
// - Control bits [7:6] pick shift, 8-bit variable, 9-bit fixed, 9-bit variable mode.
// - Shift mode moves eight bits LSB first on data pin, clock is core/12.
// - Shift mode receive starts only with receive enable set and receive done clear.
// - Writing the data buffer starts a transmission in every mode.
// - 8-bit frame is start 0, eight data bits LSB first, stop 1.
// - 8-bit transmit shifts a stop 1, transmit done set when stop bit shows.
// - Async receive starts on falling edge with enable; start bit must stay valid.
// - With extended mode off, accept only while receive done is clear.
// - 8-bit mode with filter set accepts only frames with stop bit 1.
// - Failed acceptance drops the frame and leaves receive done alone.
// - 8-bit accept stores data, stop bit into rx ninth bit, sets receive done.
// - 9-bit frames are start, eight data, ninth bit, stop 1.
// - Fixed 9-bit rate is core times 2^double over 32.
// - 9-bit transmit loads byte and tx ninth bit, done set at stop bit.
// - 9-bit mode with filter set accepts only ninth bit 1 frames.
// - 9-bit accept latches data and ninth bit, sets receive done.
// - Variable rate from Timer 1, Timer 2 or baud timer, per direction.
// - Timer 1 rate is 2^double/32 times overflow, core/(256-reload) auto-reload.
// - Timer 2 rate is overflow/16, timer counts every two cycles.
// - Extended mode receives anyway, overwrites buffer, sets lost-byte flag cleared by read.
`timescale 1ns/1ps
`default_nettype none
module fmsp_serial_port
  import fmsp_pkg::*;
(
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clkEn,
  // Special function register port
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWr,
  input wire logic sfrRd,
  input wire logic [7:0] sfrWdata,
  output logic [7:0] sfrRdata,
  // Rate and mode configuration
  input wire logic baudDouble,
  input wire logic extendedUartEnable,
  input wire logic [7:0] t1ReloadValue,
  input wire logic [15:0] t2ReloadValue,
  input wire logic [1:0] txBaudSrc,
  input wire logic [1:0] rxBaudSrc,
  input wire logic utmrTick,
  // Status
  output logic lostByteFlag,
  // Pins
  input wire logic rxdIn,
  output logic rxdOut,
  output logic rxdOe,
  output logic txdOut
);
  typedef enum logic [1:0] {IDLE = 2'b00, RUN = 2'b01, STOP = 2'b11} fmsp_state_t;
  logic [7:0] ctrl_q, ctrl_d, rxBuf_q, rxBuf_d, rdata_d;
  fmsp_tick_if ticks ();
  fmsp_baud_gen u_baud (
    .core_clk(core_clk),
    .reset(reset),
    .clkEn(clkEn),
    .mode(ctrl_q[MODE_HI_BIT:MODE_LO_BIT]),
    .baudDouble(baudDouble),
    .t1ReloadValue(t1ReloadValue),
    .t2ReloadValue(t2ReloadValue),
    .txSrc(txBaudSrc),
    .rxSrc(rxBaudSrc),
    .utmrTick(utmrTick),
    .ticks(ticks.gen)
  );
  logic rxS1_q, rxS2_q, rxPrev_q, rxPrev_d;
  fmsp_state_t txSt_q, txSt_d, rxSt_q, rxSt_d;
  logic [9:0] txSh_q, txSh_d;
  logic [3:0] txBits_q, txBits_d, txPh_q, txPh_d;
  logic [3:0] rxBits_q, rxBits_d, rxPh_q, rxPh_d;
  logic [8:0] rxSh_q, rxSh_d;
  logic [3:0] sdiv_q, sdiv_d;
  logic shRx_q, shRx_d, lost_q, lost_d;
  logic txd_q, txd_d, rxo_q, rxo_d, rxoe_q, rxoe_d;
  logic [1:0] mode;
  logic nine, wrCtrl, wrBuf, rdBuf, setTi, setRi, accept, sample;
  // First synchroniser stage only feeds the second
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rxS1_q <= 1'b1;
      rxS2_q <= 1'b1;
    end else if (clkEn) begin
      rxS1_q <= rxdIn;
      rxS2_q <= rxS1_q;
    end
  end
  assign mode = ctrl_q[MODE_HI_BIT:MODE_LO_BIT];
  assign nine = mode[1];
  assign wrCtrl = clkEn && sfrWr && sfrAddr == PORT_CONTROL_ADDR;
  assign wrBuf = clkEn && sfrWr && sfrAddr == PORT_DATA_BUFFER_ADDR;
  assign rdBuf = clkEn && sfrRd && sfrAddr == PORT_DATA_BUFFER_ADDR;
  always_comb begin
    txSt_d = txSt_q;
    rxSt_d = rxSt_q;
    txSh_d = txSh_q;
    txBits_d = txBits_q;
    txPh_d = txPh_q;
    rxBits_d = rxBits_q;
    rxPh_d = rxPh_q;
    rxSh_d = rxSh_q;
    sdiv_d = sdiv_q;
    shRx_d = shRx_q;
    txd_d = txd_q;
    rxo_d = rxo_q;
    rxoe_d = rxoe_q;
    rxPrev_d = rxPrev_q;
    setTi = 1'b0;
    setRi = 1'b0;
    accept = 1'b0;
    sample = 1'b0;
    if (clkEn) begin
      rxPrev_d = rxS2_q;
      if (mode == FMSP_MODE_SHIFT) begin
        // One engine serves both directions on the data pin
        if (txSt_q == IDLE && wrBuf) begin
          txSt_d = RUN;
          txSh_d = {2'b00, sfrWdata};
          txBits_d = 4'd0;
          sdiv_d = 4'd0;
          shRx_d = 1'b0;
          rxoe_d = 1'b1;
          rxo_d = sfrWdata[0];
        end else if (txSt_q == IDLE && ctrl_q[RX_EN_BIT] && !ctrl_q[RX_DONE_BIT]) begin
          txSt_d = RUN;
          txBits_d = 4'd0;
          sdiv_d = 4'd0;
          shRx_d = 1'b1;
          rxoe_d = 1'b0;
        end else if (txSt_q == RUN) begin
          sdiv_d = (sdiv_q == 4'(SHIFT_DIV - 1)) ? 4'd0 : sdiv_q + 4'd1;
          if (sdiv_q == 4'(SHIFT_HALF - 1)) begin
            txd_d = 1'b0;
          end
          if (sdiv_q == 4'(SHIFT_DIV - 1)) begin
            // Data is taken on the rising shift clock edge
            txd_d = 1'b1;
            txBits_d = txBits_q + 4'd1;
            if (shRx_q) begin
              rxSh_d = {1'b0, rxS2_q, rxSh_q[7:1]};
            end else begin
              txSh_d = {1'b0, txSh_q[9:1]};
              rxo_d = txSh_q[1];
            end
            if (txBits_q == 4'd7) begin
              txSt_d = IDLE;
              rxoe_d = 1'b0;
              rxo_d = 1'b0;
              if (shRx_q) begin
                setRi = 1'b1;
                accept = 1'b1;
              end else begin
                setTi = 1'b1;
              end
            end
          end
        end
      end else begin
        txd_d = (txSt_q == IDLE) ? 1'b1 : txd_q;
        rxoe_d = 1'b0;
        rxo_d = 1'b0;
        // Transmit: start, 8 data, ninth or stop, stop
        if (txSt_q == IDLE && wrBuf) begin
          txSt_d = RUN;
          txSh_d = {1'b1, nine ? ctrl_q[TX_NINTH_BIT] : 1'b1, sfrWdata};
          txBits_d = 4'd0;
          txPh_d = 4'd0;
          txd_d = 1'b0;
        end else if (txSt_q != IDLE && ticks.txTick) begin
          txPh_d = txPh_q + 4'd1;
          if (txPh_q == 4'hf) begin
            txBits_d = txBits_q + 4'd1;
            txd_d = txSh_q[0];
            txSh_d = {1'b1, txSh_q[9:1]};
            if (txBits_q == (nine ? 4'd9 : 4'd8)) begin
              txSt_d = STOP;
              setTi = 1'b1;
            end else if (txSt_q == STOP) begin
              txSt_d = IDLE;
              txd_d = 1'b1;
            end
          end
        end
        // Receive on the oversample ticks
        if (rxSt_q == IDLE) begin
          if (ctrl_q[RX_EN_BIT] && rxPrev_q && !rxS2_q) begin
            rxSt_d = RUN;
            rxPh_d = 4'd0;
            rxBits_d = 4'd0;
          end
        end else if (ticks.rxTick) begin
          rxPh_d = rxPh_q + 4'd1;
          if (rxPh_q == 4'(START_CHECK_TICK)) begin
            sample = 1'b1;
          end
        end
        if (sample) begin
          if (rxBits_q == 4'd0 && rxS2_q) begin
            rxSt_d = IDLE;
          end else begin
            rxBits_d = rxBits_q + 4'd1;
            if (rxBits_q != 4'd0) begin
              rxSh_d = {rxS2_q, rxSh_q[8:1]};
            end
            if (rxBits_q == 4'd9) begin
              rxSt_d = IDLE;
              // Tenth sample: stop bit (8-bit) or ninth bit (9-bit), tested at once
              accept = (extendedUartEnable || !ctrl_q[RX_DONE_BIT])
                && (!ctrl_q[FILTER_BIT] || rxS2_q);
              setRi = accept;
            end
          end
        end
      end
    end
  end
  always_comb begin
    ctrl_d = ctrl_q;
    rxBuf_d = rxBuf_q;
    lost_d = lost_q;
    if (wrCtrl) begin
      ctrl_d = sfrWdata;
    end
    if (rdBuf) begin
      lost_d = 1'b0;
    end
    if (accept) begin
      rxBuf_d = rxSh_d[7:0];
      if (mode != FMSP_MODE_SHIFT) begin
        ctrl_d[RX_NINTH_BIT] = rxS2_q;
        if (ctrl_q[RX_DONE_BIT]) begin
          lost_d = 1'b1;
        end
      end
    end
    // Hardware only sets; a set beats a same-cycle software clear
    if (setTi) begin
      ctrl_d[TX_DONE_BIT] = 1'b1;
    end
    if (setRi) begin
      ctrl_d[RX_DONE_BIT] = 1'b1;
    end
    rdata_d = 8'h00;
    if (sfrAddr == PORT_CONTROL_ADDR) begin
      rdata_d = ctrl_q;
    end else if (sfrAddr == PORT_DATA_BUFFER_ADDR) begin
      rdata_d = rxBuf_q;
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl_q <= PORT_CONTROL_RESET;
      rxBuf_q <= PORT_DATA_RESET;
      lost_q <= 1'b0;
      rxPrev_q <= 1'b1;
      txSt_q <= IDLE;
      rxSt_q <= IDLE;
      txSh_q <= 10'h3ff;
      txBits_q <= 4'd0;
      txPh_q <= 4'd0;
      rxBits_q <= 4'd0;
      rxPh_q <= 4'd0;
      rxSh_q <= 9'h000;
      sdiv_q <= 4'd0;
      shRx_q <= 1'b0;
      txd_q <= 1'b1;
      rxo_q <= 1'b0;
      rxoe_q <= 1'b0;
      sfrRdata <= 8'h00;
    end else begin
      ctrl_q <= ctrl_d;
      rxBuf_q <= rxBuf_d;
      lost_q <= lost_d;
      rxPrev_q <= rxPrev_d;
      txSt_q <= txSt_d;
      rxSt_q <= rxSt_d;
      txSh_q <= txSh_d;
      txBits_q <= txBits_d;
      txPh_q <= txPh_d;
      rxBits_q <= rxBits_d;
      rxPh_q <= rxPh_d;
      rxSh_q <= rxSh_d;
      sdiv_q <= sdiv_d;
      shRx_q <= shRx_d;
      txd_q <= txd_d;
      rxo_q <= rxo_d;
      rxoe_q <= rxoe_d;
      sfrRdata <= clkEn ? rdata_d : sfrRdata;
    end
  end
  assign lostByteFlag = lost_q;
  assign txdOut = txd_q;
  assign rxdOut = rxo_q;
  assign rxdOe = rxoe_q;
  property p_ri_set;
    @(posedge core_clk) disable iff (reset) setRi |=> ctrl_q[RX_DONE_BIT];
  endproperty
  a_ri_set: assert property (p_ri_set) else $error("receive done not set");
  property p_ri_hold;
    @(posedge core_clk) disable iff (reset)
      (ctrl_q[RX_DONE_BIT] && !wrCtrl) |=> ctrl_q[RX_DONE_BIT];
  endproperty
  a_ri_hold: assert property (p_ri_hold) else $error("receive done cleared by hardware");
  property p_ti_hold;
    @(posedge core_clk) disable iff (reset)
      (ctrl_q[TX_DONE_BIT] && !wrCtrl) |=> ctrl_q[TX_DONE_BIT];
  endproperty
  a_ti_hold: assert property (p_ti_hold) else $error("transmit done cleared by hardware");
  property p_no_ovr;
    @(posedge core_clk) disable iff (reset)
      (accept && mode != FMSP_MODE_SHIFT) |-> (extendedUartEnable || !ctrl_q[RX_DONE_BIT]);
  endproperty
  a_no_ovr: assert property (p_no_ovr) else $error("overwrite without extended mode");
  property p_filter;
    @(posedge core_clk) disable iff (reset)
      (accept && mode != FMSP_MODE_SHIFT && ctrl_q[FILTER_BIT]) |=> ctrl_q[RX_NINTH_BIT];
  endproperty
  a_filter: assert property (p_filter) else $error("filtered frame accepted");
  property p_start_low;
    @(posedge core_clk) disable iff (reset)
      (clkEn && wrBuf && txSt_q == IDLE && mode != FMSP_MODE_SHIFT) |=> !txdOut;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit not low");
  property p_lost;
    @(posedge core_clk) disable iff (reset)
      (accept && mode != FMSP_MODE_SHIFT && ctrl_q[RX_DONE_BIT] && !rdBuf) |=> lostByteFlag;
  endproperty
  a_lost: assert property (p_lost) else $error("lost byte flag missing");
  property p_shift_oe;
    @(posedge core_clk) disable iff (reset)
      (mode != FMSP_MODE_SHIFT && $past(mode) != FMSP_MODE_SHIFT) |-> !rxdOe;
  endproperty
  a_shift_oe: assert property (p_shift_oe) else $error("data pin driven in uart mode");
endmodule // fmsp_serial_port
`default_nettype wire

// File: pkg/fmsp_pkg.sv
// Constants and types shared by the four-mode serial port
package fmsp_pkg;
  localparam logic [7:0] PORT_CONTROL_ADDR = 8'h98;
  localparam logic [7:0] PORT_DATA_BUFFER_ADDR = 8'h99;
  // Control register bit positions
  localparam int MODE_HI_BIT = 7;
  localparam int MODE_LO_BIT = 6;
  localparam int FILTER_BIT = 5;
  localparam int RX_EN_BIT = 4;
  localparam int TX_NINTH_BIT = 3;
  localparam int RX_NINTH_BIT = 2;
  localparam int TX_DONE_BIT = 1;
  localparam int RX_DONE_BIT = 0;
  localparam logic [7:0] PORT_CONTROL_RESET = 8'h00;
  localparam logic [7:0] PORT_DATA_RESET = 8'h00;
  // Cycle counts
  localparam int SHIFT_DIV = 12;
  localparam int SHIFT_HALF = SHIFT_DIV / 2;
  localparam int FIXED_BAUD_DIV = 32;
  localparam int OVERSAMPLE = 16;
  localparam int T2_PRESCALE = 2;
  localparam int T1_RANGE = 256;
  localparam int START_CHECK_TICK = 7;
  typedef enum logic [1:0] {
    FMSP_MODE_SHIFT = 2'b00,
    FMSP_MODE_UART8 = 2'b01,
    FMSP_MODE_UART9F = 2'b10,
    FMSP_MODE_UART9V = 2'b11
  } fmsp_mode_t;
  typedef enum logic [1:0] {
    FMSP_BAUD_T1 = 2'b00,
    FMSP_BAUD_T2 = 2'b01,
    FMSP_BAUD_UTMR = 2'b10
  } fmsp_baud_src_t;
endpackage

// File: pkg/fmsp_tick_if.sv
// Tick bundle from the rate generator to the serial engine
`timescale 1ns/1ps
`default_nettype none
interface fmsp_tick_if;
  logic txTick;
  logic rxTick;
  modport gen (output txTick, output rxTick);
  modport eng (input txTick, input rxTick);
endinterface
`default_nettype wire

// File: design/fmsp_baud_gen.sv
// Oversample tick generator for the UART modes
`timescale 1ns/1ps
`default_nettype none
module fmsp_baud_gen
  import fmsp_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clkEn,
  // Rate control
  input wire logic [1:0] mode,
  input wire logic baudDouble,
  input wire logic [7:0] t1ReloadValue,
  input wire logic [15:0] t2ReloadValue,
  input wire logic [1:0] txSrc,
  input wire logic [1:0] rxSrc,
  input wire logic utmrTick,
  // Ticks, sixteen per bit
  fmsp_tick_if.gen ticks
);
  logic [7:0] t1Cnt_q, t1Cnt_d;
  logic [15:0] t2Cnt_q, t2Cnt_d;
  logic t2Pre_q, t2Pre_d;
  logic t1Div_q, t1Div_d;
  logic [4:0] fixCnt_q, fixCnt_d;
  logic t1Ovf, t2Ovf, t1Tick, fixTick, txT, rxT;
  always_comb begin
    t1Ovf = clkEn && (t1Cnt_q == 8'hff);
    t1Cnt_d = t1Cnt_q;
    t1Div_d = t1Div_q;
    t2Pre_d = t2Pre_q;
    t2Cnt_d = t2Cnt_q;
    fixCnt_d = fixCnt_q;
    t2Ovf = 1'b0;
    if (clkEn) begin
      // Auto-reload timer: rate is core / (256 - reload)
      t1Cnt_d = t1Ovf ? t1ReloadValue : t1Cnt_q + 8'h01;
      // Without double, two overflows per tick: 32 per bit
      if (t1Ovf) begin
        t1Div_d = ~t1Div_q;
      end
      // Timer 2 counts every second cycle
      t2Pre_d = ~t2Pre_q;
      if (t2Pre_q) begin
        t2Ovf = (t2Cnt_q == 16'hffff);
        t2Cnt_d = t2Ovf ? t2ReloadValue : t2Cnt_q + 16'h0001;
      end
      // Fixed rate: 32 or 16 cycles per bit, 16 ticks per bit
      fixCnt_d = fixCnt_q + 5'd1;
    end
  end
  assign t1Tick = t1Ovf && (baudDouble || t1Div_q);
  assign fixTick = clkEn && (baudDouble || fixCnt_q[0]);
  always_comb begin
    // Transmit and receive pick their own source
    unique case (txSrc)
      FMSP_BAUD_T2: txT = t2Ovf;
      FMSP_BAUD_UTMR: txT = utmrTick && clkEn;
      default: txT = t1Tick;
    endcase
    unique case (rxSrc)
      FMSP_BAUD_T2: rxT = t2Ovf;
      FMSP_BAUD_UTMR: rxT = utmrTick && clkEn;
      default: rxT = t1Tick;
    endcase
    if (mode == FMSP_MODE_UART9F) begin
      txT = fixTick;
      rxT = fixTick;
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      t1Cnt_q <= 8'h00;
      t2Cnt_q <= 16'hffff; // At the top, so the first reload comes at once
      t2Pre_q <= 1'b0;
      t1Div_q <= 1'b0;
      fixCnt_q <= 5'd0;
      ticks.txTick <= 1'b0;
      ticks.rxTick <= 1'b0;
    end else if (clkEn) begin
      t1Cnt_q <= t1Cnt_d;
      t2Cnt_q <= t2Cnt_d;
      t2Pre_q <= t2Pre_d;
      t1Div_q <= t1Div_d;
      fixCnt_q <= fixCnt_d;
      ticks.txTick <= txT;
      ticks.rxTick <= rxT;
    end
  end
  property p_fixed_rate;
    @(posedge core_clk) disable iff (reset)
      (clkEn && mode == FMSP_MODE_UART9F && !baudDouble && fixCnt_q[0]) |=> ticks.txTick;
  endproperty
  a_fixed_rate: assert property (p_fixed_rate) else $error("fixed tick missing");
  property p_t2_prescale;
    @(posedge core_clk) disable iff (reset)
      (clkEn && !t2Pre_q) |-> !t2Ovf;
  endproperty
  a_t2_prescale: assert property (p_t2_prescale) else $error("timer 2 overflow on odd cycle");
endmodule // fmsp_baud_gen
`default_nettype wire

// File: dv/fmsp_peer.sv
// Serial peer model: UART line partner and shift-register peripheral
`timescale 1ns/1ps
`default_nettype none
module fmsp_peer (
  // Clock
  input wire logic core_clk,
  // Lines from the port
  input wire logic txdOut,
  input wire logic rxdOut,
  input wire logic rxdOe,
  // Line toward the port, idles high like a pulled-up wire
  output wire logic peerRxd
);
  logic uartLine = 1'h1;
  logic m0Line = 1'h1;
  logic lastTxd = 1'h1;
  logic cur = 1'h0;
  logic curOk = 1'h0;
  int lastFall = 0;
  logic [7:0] m0Got = 8'h00;
  logic [7:0] m0Send = 8'hff;
  int m0Rises = 0;
  int cyc = 0;
  int lastRise = 0;
  int m0Period = 0;
  assign peerRxd = uartLine & m0Line;
  // Shift peripheral works off the port's shift clock, LSB first
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    lastTxd <= txdOut;
    if (rxdOe && !txdOut) begin
      cur <= rxdOut;
      curOk <= 1'h1;
    end
    if (txdOut && !lastTxd) begin
      m0Rises <= m0Rises + 1;
      m0Period <= cyc - lastRise;
      lastRise <= cyc;
      // Port drops its drive at the last rise, so go by the low phase
      if (curOk) m0Got <= {cur, m0Got[7:1]};
      curOk <= 1'h0;
    end
    // Line released to its pull-up once a bit time passes without a fall
    if (cyc - lastFall > 12) m0Line <= 1'h1;
    // New bit on the falling clock, well before the port samples it
    if (!txdOut && lastTxd && !rxdOe) begin
      m0Line <= m0Send[0];
      m0Send <= {1'h1, m0Send[7:1]};
      lastFall <= cyc;
    end
  end
  // Start bit, n bits LSB first, then idle high
  task automatic send(input logic [9:0] bits, input int n, input int bitCyc);
    int i;
    @(posedge core_clk);
    #1 uartLine = 1'h0;
    repeat (bitCyc) @(posedge core_clk);
    for (i = 0; i < n; i++) begin
      #1 uartLine = bits[i];
      repeat (bitCyc) @(posedge core_clk);
    end
    #1 uartLine = 1'h1;
  endtask
  // Short low pulse that must not pass as a start bit
  task automatic glitch();
    @(posedge core_clk);
    #1 uartLine = 1'h0;
    repeat (3) @(posedge core_clk);
    #1 uartLine = 1'h1;
  endtask
  // Times data bit 0 (must be 1, bit 1 must be 0), samples the rest mid-bit
  task automatic capture(input int n, output logic [10:0] bits, output int len);
    int i;
    int j;
    bits = '0;
    len = 0;
    i = 0;
    while (txdOut !== 1'h0 && i < 4000) begin
      @(posedge core_clk);
      i++;
    end
    while (txdOut !== 1'h1 && i < 4000) begin
      @(posedge core_clk);
      i++;
    end
    while (txdOut !== 1'h0 && i < 4000) begin
      @(posedge core_clk);
      len++;
      i++;
    end
    bits[0] = 1'h1;
    repeat (len / 2) @(posedge core_clk);
    for (j = 1; j < n; j++) begin
      if (j > 1) repeat (len) @(posedge core_clk);
      bits[j] = txdOut;
    end
  endtask
endmodule // fmsp_peer
`default_nettype wire

// File: dv/tb_fmsp_serial_port.sv
// Self-checking bench for the four-mode serial port
`timescale 1ns/1ps
`default_nettype none
module tb_fmsp_serial_port;
  import fmsp_pkg::*;
  logic core_clk = 1'h0;
  logic reset = 1'h1;
  logic [7:0] sfrAddr = 8'h00;
  logic sfrWr = 1'h0;
  logic sfrRd = 1'h0;
  logic [7:0] sfrWdata = 8'h00;
  logic [7:0] sfrRdata;
  logic baudDouble = 1'h0;
  logic extendedUartEnable = 1'h0;
  logic [7:0] t1ReloadValue = 8'hff;
  logic [15:0] t2ReloadValue = 16'hffff;
  logic [1:0] txBaudSrc = 2'h2;
  logic [1:0] rxBaudSrc = 2'h2;
  logic utmrTick = 1'h0;
  logic lostByteFlag;
  logic rxdOut;
  logic rxdOe;
  logic txdOut;
  wire logic peerRxd;
  wire logic rxdWire;
  int n_fail = 0;
  int n_compared = 0;
  logic [10:0] got;
  int len;
  logic [7:0] rd;
  always #4 core_clk = ~core_clk;
  // Baud timer ticks every second cycle, so a bit lasts 32 cycles
  always @(posedge core_clk) #1 utmrTick = ~utmrTick;
  assign rxdWire = rxdOe ? rxdOut : peerRxd;
  fmsp_serial_port DUT (.core_clk(core_clk), .reset(reset), .clkEn(1'h1),
    .sfrAddr(sfrAddr), .sfrWr(sfrWr), .sfrRd(sfrRd), .sfrWdata(sfrWdata),
    .sfrRdata(sfrRdata), .baudDouble(baudDouble), .extendedUartEnable(extendedUartEnable),
    .t1ReloadValue(t1ReloadValue), .t2ReloadValue(t2ReloadValue), .txBaudSrc(txBaudSrc),
    .rxBaudSrc(rxBaudSrc), .utmrTick(utmrTick), .lostByteFlag(lostByteFlag),
    .rxdIn(rxdWire), .rxdOut(rxdOut), .rxdOe(rxdOe), .txdOut(txdOut));
  fmsp_peer peer (.core_clk(core_clk), .txdOut(txdOut), .rxdOut(rxdOut), .rxdOe(rxdOe),
    .peerRxd(peerRxd));
  task automatic check(input string what, input logic [10:0] exp, input logic [10:0] seen);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1 sfrAddr = a;
    sfrWdata = d;
    sfrWr = 1'h1;
    @(posedge core_clk);
    #1 sfrWr = 1'h0;
  endtask
  task automatic rdr(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    #1 sfrAddr = a;
    sfrRd = 1'h1;
    @(posedge core_clk);
    #1 d = sfrRdata;
    sfrRd = 1'h0;
  endtask
  task automatic wait_flag(input int b);
    int i;
    for (i = 0; i < 800; i++) begin
      rdr(PORT_CONTROL_ADDR, rd);
      if (rd[b] === 1'h1) break;
    end
  endtask
  task automatic tx_frame(input logic [7:0] ctrl, input logic [7:0] data, input int n,
      input logic [10:0] expBits, input int expLen);
    wr(PORT_CONTROL_ADDR, ctrl);
    wr(PORT_DATA_BUFFER_ADDR, data);
    peer.capture(n, got, len);
    rdr(PORT_CONTROL_ADDR, rd);
    check("done at stop bit", 11'(ctrl | 8'h02), 11'(rd));
    check("frame bits", expBits, got);
    check("bit length", 11'(expLen), 11'(len));
    repeat (expLen) @(posedge core_clk);
    wr(PORT_CONTROL_ADDR, ctrl);
    rdr(PORT_CONTROL_ADDR, rd);
    check("done cleared", 11'(ctrl), 11'(rd));
  endtask
  task automatic rx_frame(input logic [9:0] bits, input int n, input logic [7:0] expCtrl);
    peer.send(bits, n, 32);
    repeat (8) @(posedge core_clk);
    rdr(PORT_CONTROL_ADDR, rd);
    check("rx control", 11'(expCtrl), 11'(rd));
  endtask
  task automatic rx_data(input logic [7:0] exp);
    rdr(PORT_DATA_BUFFER_ADDR, rd);
    check("rx buffer", 11'(exp), 11'(rd));
  endtask
  task automatic t_reset();
    rdr(PORT_CONTROL_ADDR, rd);
    check("control reset", 11'(PORT_CONTROL_RESET), 11'(rd));
    rdr(8'h9a, rd);
    check("unmapped read", 11'h000, 11'(rd));
    check("idle pins", 11'h004, 11'({txdOut, rxdOe, lostByteFlag}));
    $display("test reset done");
  endtask
  task automatic t_mode0();
    int r;
    wr(PORT_CONTROL_ADDR, 8'h00);
    wr(PORT_DATA_BUFFER_ADDR, 8'ha5);
    wait_flag(TX_DONE_BIT);
    check("shift tx done", 11'h002, 11'(rd));
    check("shift tx byte", 11'h0a5, 11'(peer.m0Got));
    check("shift clock period", 11'(SHIFT_DIV), 11'(peer.m0Period));
    wr(PORT_CONTROL_ADDR, 8'h00);
    r = peer.m0Rises;
    repeat (60) @(posedge core_clk);
    check("no clock without enable", 11'(r), 11'(peer.m0Rises));
    peer.m0Send = 8'h3c;
    wr(PORT_CONTROL_ADDR, 8'h10);
    wait_flag(RX_DONE_BIT);
    repeat (12) @(posedge core_clk);
    r = peer.m0Rises;
    repeat (60) @(posedge core_clk);
    check("no restart while done", 11'(r), 11'(peer.m0Rises));
    rx_data(8'h3c);
    wr(PORT_CONTROL_ADDR, 8'h00);
    $display("test shift mode done");
  endtask
  task automatic t_rates();
    tx_frame(8'h40, 8'ha5, 9, 11'h1a5, 32);
    baudDouble = 1'h1;
    txBaudSrc = FMSP_BAUD_T1;
    tx_frame(8'h40, 8'ha5, 9, 11'h1a5, 16);
    t1ReloadValue = 8'hfe;
    tx_frame(8'h40, 8'ha5, 9, 11'h1a5, 32);
    baudDouble = 1'h0;
    t1ReloadValue = 8'hff;
    tx_frame(8'h40, 8'ha5, 9, 11'h1a5, 32);
    txBaudSrc = FMSP_BAUD_T2;
    tx_frame(8'h40, 8'ha5, 9, 11'h1a5, 32);
    tx_frame(8'h80, 8'hc9, 10, 11'h2c9, 32);
    baudDouble = 1'h1;
    tx_frame(8'h80, 8'hc9, 10, 11'h2c9, 16);
    txBaudSrc = FMSP_BAUD_UTMR;
    tx_frame(8'hc8, 8'h35, 10, 11'h335, 32);
    $display("test transmit rates done");
  endtask
  task automatic t_rx8();
    wr(PORT_CONTROL_ADDR, 8'h50);
    rx_frame(10'h196, 9, 8'h55);
    rx_data(8'h96);
    rx_frame(10'h111, 9, 8'h55);
    rx_data(8'h96);
    wr(PORT_CONTROL_ADDR, 8'h70);
    rx_frame(10'h022, 9, 8'h70);
    peer.glitch();
    repeat (400) @(posedge core_clk);
    rdr(PORT_CONTROL_ADDR, rd);
    check("glitch ignored", 11'h070, 11'(rd));
    rx_frame(10'h14b, 9, 8'h75);
    rx_data(8'h4b);
    $display("test 8-bit receive done");
  endtask
  task automatic t_rx9();
    wr(PORT_CONTROL_ADDR, 8'hf0);
    rx_frame(10'h23a, 10, 8'hf0);
    rx_frame(10'h3c3, 10, 8'hf5);
    rx_data(8'hc3);
    wr(PORT_CONTROL_ADDR, 8'hd0);
    rx_frame(10'h25e, 10, 8'hd1);
    rx_data(8'h5e);
    $display("test 9-bit receive done");
  endtask
  task automatic t_lost();
    extendedUartEnable = 1'h1;
    wr(PORT_CONTROL_ADDR, 8'h50);
    rx_frame(10'h161, 9, 8'h55);
    rx_frame(10'h162, 9, 8'h55);
    check("lost flag set", 11'h001, 11'(lostByteFlag));
    rx_data(8'h62);
    @(posedge core_clk);
    #1 check("lost flag cleared", 11'h000, 11'(lostByteFlag));
    extendedUartEnable = 1'h0;
    $display("test overwrite done");
  endtask
  task automatic print_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    #1 reset = 1'h0;
    t_reset();
    t_mode0();
    t_rates();
    t_rx8();
    t_rx9();
    t_lost();
    print_verdict();
  end
  // Whole run needs about 6500 cycles
  initial begin
    repeat (60000) @(posedge core_clk);
    n_fail++;
    print_verdict();
  end
endmodule // tb_fmsp_serial_port
`default_nettype wire
